// file: rtl/lib_sysctl_pkg.sv
// Package: offsets, field positions and reset values of the legacy base and system control
package lib_sysctl_pkg;
  // ----------------------------------------------------------------
  // Configuration offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_LEGACY_BASE = 8'h44;
  localparam logic [7:0] OFF_SYS_CONTROL = 8'h80;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_LEGACY_BASE = 32'h0000_0001;
  localparam logic [31:0] RST_SYS_CONTROL = 32'h0000_0020;
  // ----------------------------------------------------------------
  // System control field positions and legacy base fixed bit
  // ----------------------------------------------------------------
  localparam int POS_ROTATION_LO = 30;
  localparam int POS_TIE_FIRST_TWO = 29;
  localparam int POS_MERGE_THREE = 28;
  localparam int POS_CLOCK_DIR = 27;
  localparam int POS_ROUTE_SEL = 26;
  localparam int POS_WRITE_FLAG = 25;
  localparam int POS_WRITE_EN = 24;
  localparam int POS_RESERVED = 23;
  localparam int POS_SUBSYS_LOCK = 5;
  localparam int POS_BASE_FIXED = 0;
  // ----------------------------------------------------------------
  // Interrupt pin register codes and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN_CODE_FIRST = 8'h01;
  localparam logic [7:0] PIN_CODE_SECOND = 8'h02;
  localparam int NUM_SOCKETS = 2;
  localparam int NUM_SLOTS = 4;
  localparam int NUM_INT_IRQS = 3;
  localparam int SW_CLK_HALF_DEFAULT = 100;
  typedef enum logic [0:0] {FUNC_SOCKET0, FUNC_SOCKET1} cfg_func_t;
endpackage

// file: rtl/irq_slot_serializer.sv
// Serializer that walks the interrupt slots one per clock onto a serial line
`timescale 1ns/1ps
`default_nettype none
module irq_slot_serializer #(
  parameter int SLOTS = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [SLOTS-1:0] slot_lvl,
  output logic ser_out,
  output logic ser_frame
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (SLOTS < 2) begin : g_bad_slots
    $error("irq_slot_serializer needs at least two slots");
  end
  localparam int IW = $clog2(SLOTS);
  localparam logic [IW-1:0] LAST = IW'(SLOTS - 1);
  logic [IW-1:0] idx_r;
  logic ser_r;
  logic frame_r;
  // ----------------------------------------------------------------
  // Slot counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      idx_r <= '0;
    end else if (idx_r == LAST) begin
      idx_r <= '0;
    end else begin
      idx_r <= idx_r + 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Serial data and frame marker
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ser_r <= 1'b0;
      frame_r <= 1'b0;
    end else begin
      ser_r <= slot_lvl[idx_r]; // [RULE18]
      frame_r <= (idx_r == '0);
    end
  end
  assign ser_out = ser_r;
  assign ser_frame = frame_r;
endmodule // irq_slot_serializer
`default_nettype wire

// file: rtl/legacy_index_base_and_system_control.sv
// Legacy index port base and upper system control register bank
// Operation
// (RULE1) Base address is the index port; base plus one is the data port.
// (RULE2) Base accepts any word-aligned 32-bit I/O address; bit 0 reads one.
// (RULE3) One base register serves both socket functions; either write updates it.
// (RULE4) Base sits at 44h in both functions, resets to 0000_0001h.
// (RULE5) System control is one 32-bit register at 80h, resets to 0000_0020h.
// (RULE6) Software touches the global control bits only through function 0.
// (RULE7) Rotation field places three interrupts in slots ABC, BCD, CDA or DAB.
// (RULE8) Tie bit merges first and second interrupts onto the first; rotation applies.
// (RULE9) Tie-all merges all three onto the first and shows in the pin register.
// (RULE10) Clock direction zero: terminal is input; one: driven from internal oscillator.
// (RULE11) Route bit zero raises legacy line two; one raises card status change.
// (RULE12) Power write flag sets on a socket power write while the enable is one.
// (RULE13) Writing one to the flag clears it; writing zero leaves it.
// (RULE14) Enable one makes each power write interrupt; resets to zero.
// (RULE15) Bit 23 is reserved, read-only zero.
// (RULE16) Bit 5 locks the subsystem ID registers when one.
// (RULE17) I/O decoder claims on base match ignoring bit 0; even index, odd data.
// (RULE18) Merge first, then rotate, then serialize the interrupt stream.
`timescale 1ns/1ps
`default_nettype none
module legacy_index_base_and_system_control #(
  parameter int SW_CLK_HALF = lib_sysctl_pkg::SW_CLK_HALF_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire lib_sysctl_pkg::cfg_func_t cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic io_req,
  input wire logic io_wr,
  input wire logic [31:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic io_claim,
  output logic io_index_sel,
  output logic io_data_sel,
  output logic [7:0] legacy_index,
  input wire logic [lib_sysctl_pkg::NUM_SOCKETS-1:0] pwr_write,
  input wire logic [lib_sysctl_pkg::NUM_INT_IRQS-1:0] irq_in,
  output logic [lib_sysctl_pkg::NUM_SLOTS-1:0] irq_slot,
  output logic irq_ser_out,
  output logic irq_ser_frame,
  output logic [7:0] int_pin_f0,
  output logic [7:0] int_pin_f1,
  output logic legacy_irq_two,
  output logic card_status_change,
  input wire logic switch_clk_in,
  output logic switch_clk_out,
  output logic switch_clk_oe,
  output logic switch_clk_level,
  output logic subsys_id_write_lock
);
  import lib_sysctl_pkg::*;
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (SW_CLK_HALF < 1 || SW_CLK_HALF > 65535) begin : g_bad_half
    $error("SW_CLK_HALF must lie in 1..65535");
  end
  localparam logic [15:0] HALF_LAST = 16'(SW_CLK_HALF - 1);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:1] base_r;
  logic [1:0] rotation_r;
  logic tie_two_r;
  logic merge_three_r;
  logic clk_dir_r;
  logic route_r;
  logic write_en_r;
  logic lock_r;
  logic [NUM_SOCKETS-1:0] flag_r;
  logic [NUM_SOCKETS-1:0] flag_nxt;
  logic [31:0] rdata_r;
  logic [7:0] index_r;
  logic [NUM_SLOTS-1:0] slot_r;
  logic [NUM_SLOTS-1:0] slot_nxt;
  logic sw_s1_r;
  logic sw_s2_r;
  logic osc_r;
  logic [15:0] div_r;
  logic wr_base;
  logic wr_ctl;
  logic wr_global;
  assign wr_base = cfg_wr && (cfg_addr == OFF_LEGACY_BASE);
  assign wr_ctl = cfg_wr && (cfg_addr == OFF_SYS_CONTROL);
  assign wr_global = wr_ctl && (cfg_func == FUNC_SOCKET0); // [RULE6]
  // ----------------------------------------------------------------
  // Legacy base register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      base_r <= RST_LEGACY_BASE[31:1]; // [RULE4]
    end else if (wr_base) begin // [RULE3]
      if (cfg_be[3]) base_r[31:24] <= cfg_wdata[31:24];
      if (cfg_be[2]) base_r[23:16] <= cfg_wdata[23:16];
      if (cfg_be[1]) base_r[15:8] <= cfg_wdata[15:8];
      if (cfg_be[0]) base_r[7:1] <= cfg_wdata[7:1]; // [RULE2]
    end
  end
  // ----------------------------------------------------------------
  // Global system control bits
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rotation_r <= RST_SYS_CONTROL[POS_ROTATION_LO+:2]; // [RULE5]
      tie_two_r <= RST_SYS_CONTROL[POS_TIE_FIRST_TWO];
      merge_three_r <= RST_SYS_CONTROL[POS_MERGE_THREE];
      clk_dir_r <= RST_SYS_CONTROL[POS_CLOCK_DIR];
      route_r <= RST_SYS_CONTROL[POS_ROUTE_SEL];
      write_en_r <= RST_SYS_CONTROL[POS_WRITE_EN]; // [RULE14]
    end else if (wr_global && cfg_be[3]) begin
      rotation_r <= cfg_wdata[POS_ROTATION_LO+:2];
      tie_two_r <= cfg_wdata[POS_TIE_FIRST_TWO];
      merge_three_r <= cfg_wdata[POS_MERGE_THREE];
      clk_dir_r <= cfg_wdata[POS_CLOCK_DIR];
      route_r <= cfg_wdata[POS_ROUTE_SEL];
      write_en_r <= cfg_wdata[POS_WRITE_EN];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      lock_r <= RST_SYS_CONTROL[POS_SUBSYS_LOCK];
    end else if (wr_ctl && cfg_be[0]) begin
      lock_r <= cfg_wdata[POS_SUBSYS_LOCK];
    end
  end
  assign subsys_id_write_lock = lock_r; // [RULE16]
  // ----------------------------------------------------------------
  // Per-socket power write flags, set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    for (int s = 0; s < NUM_SOCKETS; s++) begin
      flag_nxt[s] = flag_r[s];
      if (wr_ctl && cfg_be[3] && cfg_wdata[POS_WRITE_FLAG] && (int'(cfg_func) == s)) begin
        flag_nxt[s] = 1'b0; // [RULE13]
      end
      if (pwr_write[s] && write_en_r) begin
        flag_nxt[s] = 1'b1; // [RULE12] [RULE14]
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      legacy_irq_two <= 1'b0;
      card_status_change <= 1'b0;
    end else begin
      legacy_irq_two <= (|flag_nxt) && !route_r; // [RULE11]
      card_status_change <= (|flag_nxt) && route_r; // [RULE11]
    end
  end
  // ----------------------------------------------------------------
  // Configuration read data
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_r <= '0;
    end else if (cfg_rd) begin
      rdata_r <= '0;
      if (cfg_addr == OFF_LEGACY_BASE) begin
        rdata_r <= {base_r, 1'b1}; // [RULE2]
      end else if (cfg_addr == OFF_SYS_CONTROL) begin
        rdata_r <= {rotation_r, tie_two_r, merge_three_r, clk_dir_r, route_r,
                    flag_r[cfg_func], write_en_r, 1'b0, 17'h0_0000, lock_r,
                    5'h00}; // [RULE15]
      end
    end
  end
  assign cfg_rdata = rdata_r;
  // ----------------------------------------------------------------
  // Legacy index/data I/O decode
  // ----------------------------------------------------------------
  assign io_claim = io_req && (io_addr[31:1] == base_r[31:1]); // [RULE17] [RULE1]
  assign io_index_sel = io_claim && !io_addr[0]; // [RULE1]
  assign io_data_sel = io_claim && io_addr[0];
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      index_r <= 8'h00;
    end else if (io_index_sel && io_wr) begin
      index_r <= io_wdata;
    end
  end
  assign legacy_index = index_r;
  // ----------------------------------------------------------------
  // Interrupt merge and rotation
  // ----------------------------------------------------------------
  always_comb begin
    logic [NUM_INT_IRQS-1:0] src;
    logic [1:0] pos;
    src = irq_in;
    pos = 2'b00;
    if (merge_three_r) begin
      src = {2'b00, |irq_in}; // [RULE9] [RULE18]
    end else if (tie_two_r) begin
      src = {irq_in[2], 1'b0, irq_in[0] | irq_in[1]}; // [RULE8] [RULE18]
    end
    slot_nxt = '0;
    for (int i = 0; i < NUM_INT_IRQS; i++) begin
      pos = 2'(i) + rotation_r;
      slot_nxt[pos] = slot_nxt[pos] | src[i]; // [RULE7]
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      slot_r <= '0;
    end else begin
      slot_r <= slot_nxt;
    end
  end
  assign irq_slot = slot_r;
  assign int_pin_f0 = PIN_CODE_FIRST;
  assign int_pin_f1 = merge_three_r ? PIN_CODE_FIRST : PIN_CODE_SECOND; // [RULE9]
  irq_slot_serializer #(.SLOTS(NUM_SLOTS)) u_ser (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .slot_lvl(slot_r),
    .ser_out(irq_ser_out),
    .ser_frame(irq_ser_frame)
  );
  // ----------------------------------------------------------------
  // Power switch clock terminal
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sw_s1_r <= 1'b0;
      sw_s2_r <= 1'b0;
    end else begin
      sw_s1_r <= switch_clk_in;
      sw_s2_r <= sw_s1_r;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_r <= 16'h0000;
      osc_r <= 1'b0;
    end else if (div_r == HALF_LAST) begin
      div_r <= 16'h0000;
      osc_r <= !osc_r;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  assign switch_clk_out = osc_r;
  assign switch_clk_oe = clk_dir_r; // [RULE10]
  assign switch_clk_level = clk_dir_r ? osc_r : sw_s2_r; // [RULE10]
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  base_bit_one_a: assert property ( // [RULE2]
    cfg_rd && cfg_addr == OFF_LEGACY_BASE |=> cfg_rdata[0])
    else $error("Base bit 0 did not read one");
  base_shared_a: assert property ( // [RULE3]
    wr_base && cfg_func == FUNC_SOCKET1 && cfg_be == 4'hf
    |=> {base_r, 1'b1} == {$past(cfg_wdata[31:1]), 1'b1})
    else $error("Function 1 write did not update shared base");
  decode_match_a: assert property ( // [RULE17]
    io_req && io_addr == {base_r, 1'b1} |-> io_data_sel && !io_index_sel)
    else $error("Odd base address not routed to data port");
  global_f1_a: assert property ( // [RULE6]
    wr_ctl && cfg_func == FUNC_SOCKET1 |=> $stable(route_r) && $stable(rotation_r))
    else $error("Function 1 altered a global bit");
  flag_set_a: assert property ( // [RULE12]
    pwr_write[0] && write_en_r |=> flag_r[0] && (legacy_irq_two || card_status_change))
    else $error("Power write flag or interrupt missing");
  flag_clear_a: assert property ( // [RULE13]
    wr_ctl && cfg_func == FUNC_SOCKET0 && cfg_be[3] && cfg_wdata[POS_WRITE_FLAG]
    && !pwr_write[0] |=> !flag_r[0])
    else $error("Write of one did not clear the flag");
  flag_off_a: assert property ( // [RULE14]
    !write_en_r && !flag_r[1] |=> !flag_r[1])
    else $error("Flag set while generation disabled");
  rotate_place_a: assert property ( // [RULE7]
    !tie_two_r && !merge_three_r && rotation_r == 2'b11 && irq_in == 3'b100
    |=> irq_slot == 4'b0010)
    else $error("Third interrupt not in rotated slot");
  tie_two_a: assert property ( // [RULE8]
    tie_two_r && !merge_three_r && rotation_r == 2'b01 && irq_in == 3'b010
    |=> irq_slot == 4'b0010)
    else $error("Tied interrupt not signalled in rotated first slot");
  merge_all_a: assert property ( // [RULE9]
    merge_three_r && rotation_r == 2'b00 && irq_in[2] |=> irq_slot == 4'b0001)
    else $error("Merged interrupts not on first slot");
  route_sel_a: assert property ( // [RULE11]
    flag_r[0] && !route_r && $stable(route_r) |-> !card_status_change)
    else $error("Power interrupt on wrong route");
  clk_dir_a: assert property ( // [RULE10]
    !clk_dir_r && $past(nrst, 2)
    |-> !switch_clk_oe && switch_clk_level == $past(switch_clk_in, 2))
    else $error("Clock terminal driven while input");
  rsvd_zero_a: assert property ( // [RULE15]
    cfg_rd && cfg_addr == OFF_SYS_CONTROL |=> !cfg_rdata[POS_RESERVED])
    else $error("Reserved bit 23 read nonzero");
  lock_read_a: assert property ( // [RULE16]
    cfg_rd && cfg_addr == OFF_SYS_CONTROL |=> cfg_rdata[POS_SUBSYS_LOCK] == subsys_id_write_lock)
    else $error("Lock bit read mismatch");
  ser_slot_a: assert property ( // [RULE18]
    irq_ser_frame |-> ##1 irq_ser_out == $past(slot_r[1]))
    else $error("Serial stream out of slot order");
  flag_cover_c: cover property (pwr_write[1] && write_en_r ##1 flag_r[1]);
  data_cover_c: cover property (io_data_sel && io_wr);
  merge_cover_c: cover property (merge_three_r && |irq_in);
  rot_cover_c: cover property (rotation_r == 2'b10 && |irq_slot);
endmodule // legacy_index_base_and_system_control
`default_nettype wire

// file: tb/host_cfg_model.sv
// Host model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module host_cfg_model (
  input wire logic sys_clk,
  output logic cfg_wr,
  output logic cfg_rd,
  output lib_sysctl_pkg::cfg_func_t cfg_func,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata
);
  import lib_sysctl_pkg::*;
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_func = FUNC_SOCKET0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end
  // One-cycle write strobe; released data is flipped
  task automatic cfg_write(input cfg_func_t f, input logic [7:0] a, input logic [3:0] be,
                           input logic [31:0] d);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_func <= f;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    cfg_wdata <= ~d;
  endtask
  // Read data taken one cycle after the strobe
  task automatic cfg_read(input cfg_func_t f, input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    cfg_func <= f;
    cfg_addr <= a;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    @(negedge sys_clk);
    d = cfg_rdata;
  endtask
endmodule // host_cfg_model
`default_nettype wire

// file: tb/tb_legacy_index_base_and_system_control.sv
// Testbench for the legacy base and system control bank
`timescale 1ns/1ps
`default_nettype none
module tb_legacy_index_base_and_system_control;
  import lib_sysctl_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic io_req = 1'b0;
  logic io_wr = 1'b0;
  logic [31:0] io_addr = 32'h0;
  logic [7:0] io_wdata = 8'h0;
  logic [1:0] pwr_write = 2'b00;
  logic [2:0] irq_in = 3'b000;
  logic switch_clk_in = 1'b0;
  logic cfg_wr, cfg_rd, io_claim, io_index_sel, io_data_sel, ser_out, ser_frame;
  cfg_func_t cfg_func;
  logic [7:0] cfg_addr, legacy_index, pin_f0, pin_f1;
  logic [3:0] cfg_be, irq_slot;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic irq_two, status_chg, clk_out, clk_oe, clk_level, lock;
  int bad_count = 0;
  int total_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  host_cfg_model host (.sys_clk(sys_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_func(cfg_func),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  legacy_index_base_and_system_control #(.SW_CLK_HALF(2)) uut (.sys_clk(sys_clk), .nrst(nrst),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .io_req(io_req), .io_wr(io_wr),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_claim(io_claim), .io_index_sel(io_index_sel),
    .io_data_sel(io_data_sel), .legacy_index(legacy_index), .pwr_write(pwr_write),
    .irq_in(irq_in), .irq_slot(irq_slot), .irq_ser_out(ser_out), .irq_ser_frame(ser_frame),
    .int_pin_f0(pin_f0), .int_pin_f1(pin_f1), .legacy_irq_two(irq_two),
    .card_status_change(status_chg), .switch_clk_in(switch_clk_in), .switch_clk_out(clk_out),
    .switch_clk_oe(clk_oe), .switch_clk_level(clk_level), .subsys_id_write_lock(lock));
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd_chk(input string name, input cfg_func_t f, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] v;
    host.cfg_read(f, a, v);
    chk(name, exp, v);
  endtask
  task automatic sc_wr(input cfg_func_t f, input logic [31:0] d);
    host.cfg_write(f, OFF_SYS_CONTROL, 4'hf, d);
    @(negedge sys_clk);
  endtask
  task automatic pulse_pwr(input logic [1:0] s);
    @(posedge sys_clk);
    pwr_write <= s;
    @(posedge sys_clk);
    pwr_write <= 2'b00;
    @(negedge sys_clk);
  endtask
  task automatic io_cyc(input logic [31:0] a, input logic [7:0] d, input logic [2:0] exp);
    @(posedge sys_clk);
    io_req <= 1'b1;
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(negedge sys_clk);
    chk("io decode", {29'h0, exp}, {29'h0, io_claim, io_index_sel, io_data_sel});
    @(posedge sys_clk);
    io_req <= 1'b0;
    io_addr <= ~a;
    @(negedge sys_clk);
  endtask
  function automatic logic [3:0] slot_exp(input int rot, input int mode, input logic [2:0] p);
    logic [2:0] s;
    logic [3:0] e;
    s = p;
    if (mode == 2) begin
      s = {2'b00, |p};
    end else if (mode == 1) begin
      s = {p[2], 1'b0, p[0] | p[1]};
    end
    e = 4'h0;
    for (int k = 0; k < 3; k++) begin
      if (s[k]) e[(k + rot) % 4] = 1'b1;
    end
    return e;
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    logic lv;
    int n;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk("lock reset", 32'h1, {31'h0, lock});
    chk("oe reset", 32'h0, {31'h0, clk_oe});
    rd_chk("base reset", FUNC_SOCKET0, OFF_LEGACY_BASE, 32'h0000_0001);
    rd_chk("sysctl reset", FUNC_SOCKET1, OFF_SYS_CONTROL, 32'h0000_0020);
    rd_chk("unmapped", FUNC_SOCKET0, 8'h48, 32'h0);
    $display("test reset done");
    host.cfg_write(FUNC_SOCKET1, OFF_LEGACY_BASE, 4'hf, 32'h1234_5670);
    rd_chk("base f0", FUNC_SOCKET0, OFF_LEGACY_BASE, 32'h1234_5671);
    host.cfg_write(FUNC_SOCKET0, OFF_LEGACY_BASE, 4'hf, 32'h0000_0300);
    rd_chk("base f1", FUNC_SOCKET1, OFF_LEGACY_BASE, 32'h0000_0301);
    io_cyc(32'h0000_0300, 8'h5a, 3'b110);
    chk("index", 32'h5a, {24'h0, legacy_index});
    io_cyc(32'h0000_0301, 8'h33, 3'b101);
    io_cyc(32'h0000_0302, 8'h77, 3'b000);
    io_cyc(32'h8000_0300, 8'h11, 3'b000);
    chk("index kept", 32'h5a, {24'h0, legacy_index});
    $display("test base and decode done");
    sc_wr(FUNC_SOCKET0, 32'h0080_0000);
    chk("lock off", 32'h0, {31'h0, lock});
    rd_chk("reserved", FUNC_SOCKET0, OFF_SYS_CONTROL, 32'h0);
    sc_wr(FUNC_SOCKET1, 32'hff00_0020);
    rd_chk("f1 global", FUNC_SOCKET0, OFF_SYS_CONTROL, 32'h0000_0020);
    chk("lock on", 32'h1, {31'h0, lock});
    pulse_pwr(2'b01);
    chk("no irq", 32'h0, {30'h0, irq_two, status_chg});
    sc_wr(FUNC_SOCKET0, 32'h0100_0020);
    pulse_pwr(2'b01);
    chk("irq two", 32'h2, {30'h0, irq_two, status_chg});
    rd_chk("flag0", FUNC_SOCKET0, OFF_SYS_CONTROL, 32'h0300_0020);
    rd_chk("flag1", FUNC_SOCKET1, OFF_SYS_CONTROL, 32'h0100_0020);
    sc_wr(FUNC_SOCKET0, 32'h0100_0020);
    rd_chk("flag kept", FUNC_SOCKET0, OFF_SYS_CONTROL, 32'h0300_0020);
    fork
      sc_wr(FUNC_SOCKET0, 32'h0300_0020);
      pulse_pwr(2'b01);
    join
    rd_chk("set wins", FUNC_SOCKET0, OFF_SYS_CONTROL, 32'h0300_0020);
    sc_wr(FUNC_SOCKET0, 32'h0300_0020);
    chk("rdata holds", 32'h0300_0020, cfg_rdata);
    chk("irq cleared", 32'h0, {30'h0, irq_two, status_chg});
    sc_wr(FUNC_SOCKET0, 32'h0500_0020);
    pulse_pwr(2'b10);
    chk("status change", 32'h1, {30'h0, irq_two, status_chg});
    rd_chk("flag1 set", FUNC_SOCKET1, OFF_SYS_CONTROL, 32'h0700_0020);
    sc_wr(FUNC_SOCKET1, 32'h0200_0020);
    rd_chk("flag1 clr", FUNC_SOCKET1, OFF_SYS_CONTROL, 32'h0500_0020);
    chk("status change cleared", 32'h0, {30'h0, irq_two, status_chg});
    $display("test power flags done");
    sc_wr(FUNC_SOCKET0, 32'h0800_0020);
    chk("oe on", 32'h1, {31'h0, clk_oe});
    lv = clk_level;
    n = 0;
    while (clk_level === lv && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk("osc toggles", 32'h1, {31'h0, clk_level !== lv});
    chk("osc out", {31'h0, clk_out}, {31'h0, clk_level});
    if (clk_level === lv) end_sim();
    sc_wr(FUNC_SOCKET0, 32'h0000_0020);
    chk("oe off", 32'h0, {31'h0, clk_oe});
    for (int b = 1; b >= 0; b--) begin
      @(posedge sys_clk);
      switch_clk_in <= b[0];
      repeat (4) @(negedge sys_clk);
      chk("pin level", b, {31'h0, clk_level});
    end
    $display("test clock direction done");
    for (int rot = 0; rot < 4; rot++) begin
      for (int mode = 0; mode < 3; mode++) begin
        sc_wr(FUNC_SOCKET0, {rot[1:0], mode == 1, mode == 2, 28'h000_0020});
        chk("pin f0", 32'h01, {24'h0, pin_f0});
        chk("pin f1", (mode == 2) ? 32'h01 : 32'h02, {24'h0, pin_f1});
        for (int p = 1; p < 8; p++) begin
          @(posedge sys_clk);
          irq_in <= p[2:0];
          repeat (2) @(posedge sys_clk);
          @(negedge sys_clk);
          chk("slots", {28'h0, slot_exp(rot, mode, p[2:0])}, {28'h0, irq_slot});
        end
      end
    end
    sc_wr(FUNC_SOCKET0, 32'h4000_0020);
    @(posedge sys_clk);
    irq_in <= 3'b011;
    repeat (3) @(negedge sys_clk);
    n = 0;
    while (ser_frame !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 8) begin
      chk("frame seen", 32'h1, 32'h0);
      end_sim();
    end
    for (int k = 0; k < 4; k++) begin
      chk("serial", {28'h0, slot_exp(1, 0, 3'b011) >> k & 4'h1}, {31'h0, ser_out});
      @(negedge sys_clk);
    end
    $display("test interrupt slots done");
    end_sim();
  end
endmodule // tb_legacy_index_base_and_system_control
`default_nettype wire
